// ### ictc_params.svh
// Offsets, field positions, reset values and timing codes of the channel timing block
`ifndef ICTC_PARAMS_SVH
`define ICTC_PARAMS_SVH
`define ICTC_PRI_OFFSET 8'h40
`define ICTC_SEC_OFFSET 8'h42
`define ICTC_SLV_OFFSET 8'h44
`define ICTC_TIM_RESET 16'h0000
`define ICTC_TIM_WMASK 16'hF3FF
`define ICTC_BIT_DECODE 15
`define ICTC_BIT_SEPARATE 14
`define ICTC_SMP_HI 13
`define ICTC_SMP_LO 12
`define ICTC_RTC_HI 9
`define ICTC_RTC_LO 8
`define ICTC_BIT_D1_DMA_ONLY 7
`define ICTC_BIT_D1_PREFETCH 6
`define ICTC_BIT_D1_READY_EN 5
`define ICTC_BIT_D1_FAST_BANK 4
`define ICTC_BIT_DTE0 3
`define ICTC_BIT_PPE0 2
`define ICTC_BIT_IE0 1
`define ICTC_BIT_TIME0 0
`define ICTC_SMP_BASE 4'h5
`define ICTC_RTC_BASE 4'h4
`define ICTC_DRVHEAD_PORT 3'h6
`define ICTC_DRVSEL_BIT 4
`endif

// ### ictc_pkg.sv
// Types shared by the channel timing block
package ictc_pkg;
  typedef enum logic [4:0] {
    ICTC_IDLE = 5'b00001,
    ICTC_STROBE = 5'b00010,
    ICTC_WAIT = 5'b00100,
    ICTC_RECOVER = 5'b01000,
    ICTC_DONE = 5'b10000
  } ictc_state_e;
  typedef enum logic [1:0] {
    ICTC_TIM_COMPAT8 = 2'h0,
    ICTC_TIM_COMPAT16 = 2'h1,
    ICTC_TIM_FAST = 2'h2
  } ictc_timing_e;
endpackage

// ### ictc_cycle.sv
// One channel's cable cycle sequencer: strobe, ready sample and recovery
`timescale 1ns/10ps
`include "ictc_params.svh"
module ictc_cycle #(
  parameter int CW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Request
  input wire logic start,
  input wire logic [1:0] smp_code,
  input wire logic [1:0] rtc_code,
  input wire logic ready_en,
  // Cable
  input wire logic iordy,
  output logic strobe,
  output logic busy,
  output logic sample_pulse
);
  initial begin
    if (CW < 3) $error("ictc_cycle: CW too small");
  end
  ictc_pkg::ictc_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ready_int;
  // ==========================================================
  // Sequencer
  assign ready_int = !ready_en || iordy;
  assign strobe = (st_q == ictc_pkg::ICTC_STROBE) ||
                  (st_q == ictc_pkg::ICTC_WAIT);
  assign busy = (st_q != ictc_pkg::ICTC_IDLE);
  assign sample_pulse = (st_q == ictc_pkg::ICTC_WAIT);
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ictc_pkg::ICTC_IDLE: begin
        if (start) begin
          st_d = ictc_pkg::ICTC_STROBE;
          cnt_d = CW'(`ICTC_SMP_BASE - {2'h0, smp_code} - 4'h2);
        end
      end
      ictc_pkg::ICTC_STROBE: begin
        if (cnt_q == '0) st_d = ictc_pkg::ICTC_WAIT;
        else cnt_d = cnt_q - CW'(1);
      end
      ictc_pkg::ICTC_WAIT: begin
        if (ready_int) begin
          st_d = ictc_pkg::ICTC_RECOVER;
          cnt_d = CW'(`ICTC_RTC_BASE - {2'h0, rtc_code} - 4'h1);
        end
      end
      ictc_pkg::ICTC_RECOVER: begin
        if (cnt_q == '0) st_d = ictc_pkg::ICTC_DONE;
        else cnt_d = cnt_q - CW'(1);
      end
      ictc_pkg::ICTC_DONE: st_d = ictc_pkg::ICTC_IDLE;
      default: st_d = ictc_pkg::ICTC_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ictc_pkg::ICTC_IDLE;
      cnt_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
  // ==========================================================
  // Checks
  first_sample_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && start && !busy && smp_code == 2'h3) ##1 clk_en
    |=> sample_pulse) else $error("sample point late");
  forced_ready_a: assert property (@(posedge clk_sys) disable iff (srst)
    (sample_pulse && !ready_en && clk_en) |=> !sample_pulse)
    else $error("forced ready not honoured");
endmodule // ictc_cycle

// ### ictc_channel_timing.sv
// Channel timing registers, decode and cable cycle control for two cables
`timescale 1ns/10ps
`include "ictc_params.svh"
// Operation
// - Two independent timing registers, primary at 40h, secondary at 42h.
// - Decode enable set: claim command and control block I/O, run on cable.
// - Decode enable clear: do not claim; leave to subtractive decode.
// - Separate enable set: drive 1 takes sample and recovery from slave register.
// - Separate enable clear: this register's sample and recovery govern both drives.
// - Sample point codes 00..11 give 5,4,3,2 clocks after strobe.
// - Recovery codes 00..11 give at least 4,3,2,1 clocks before next strobe.
// - Drive-1 DMA-only bit clear: fast timing for drive-1 DMA and PIO.
// - Drive-1 DMA-only bit set: fast only for DMA, PIO compatible.
// - Drive-1 prefetch and posting only while its enable bit set.
// - Drive-1 ready sampling off: internal ready forced asserted.
// - Drive-1 ready sampling on and drive 1 selected: sample ready.
// - Fast bank bit clear: 16-bit compatible data timing; set: fast.
// - Non-data ports always use 8-bit compatible timing.
module ictc_channel_timing #(
  parameter int CW = 4
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // Slave drive timing fields, per channel {rtc, isp}
  input wire logic [3:0] slv_timing_pri,
  input wire logic [3:0] slv_timing_sec,
  // ATA block I/O request
  input wire logic io_req,
  input wire logic io_wr,
  input wire logic io_dma,
  input wire logic io_chan,
  input wire logic io_ctrl_blk,
  input wire logic [2:0] io_reg,
  input wire logic [7:0] io_wdata,
  output logic io_claim,
  output logic io_busy,
  // Cable timing result
  output logic [1:0] cyc_timing,
  output logic cyc_prefetch_post,
  output logic cyc_drive1,
  // Cable pins per channel
  input wire logic iordy_pri,
  input wire logic iordy_sec,
  output logic strobe_pri,
  output logic strobe_sec
);
  initial begin
    if (CW < 3) $error("ictc_channel_timing: CW too small");
  end
  logic [15:0] tim_q [2];
  logic [15:0] tim_d [2];
  logic [1:0] drv_q, drv_d;
  logic [1:0] timing_q, timing_d;
  logic pp_q, pp_d, d1_q, d1_d;
  logic [1:0] busy_ch, start_ch, iordy_ch, strobe_ch, ren_ch;
  logic [1:0] smp_ch [2];
  logic [1:0] rtc_ch [2];
  logic [3:0] slv_ch [2];
  logic accept, data_port;
  logic [15:0] cur;
  // ==========================================================
  // Timing registers
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      tim_d[c] = tim_q[c];
      if (cfg_wr && cfg_addr == (c == 0 ? `ICTC_PRI_OFFSET
                                        : `ICTC_SEC_OFFSET)) begin
        if (cfg_be[0])
          tim_d[c][7:0] = cfg_wdata[7:0];
        if (cfg_be[1])
          tim_d[c][15:8] = cfg_wdata[15:8];
        tim_d[c] = tim_d[c] & `ICTC_TIM_WMASK;
      end
    end
  end
  always_comb begin
    cfg_rdata = 16'h0000;
    if (cfg_rd && cfg_addr == `ICTC_PRI_OFFSET)
      cfg_rdata = tim_q[0];
    else if (cfg_rd && cfg_addr == `ICTC_SEC_OFFSET)
      cfg_rdata = tim_q[1];
  end
  // ==========================================================
  // Request decode and drive select shadow
  assign cur = tim_q[io_chan];
  assign accept = io_req && cur[`ICTC_BIT_DECODE] && !busy_ch[io_chan];
  assign io_claim = io_req && cur[`ICTC_BIT_DECODE];
  assign io_busy = |busy_ch;
  assign data_port = !io_ctrl_blk && io_reg == 3'h0;
  always_comb begin
    drv_d = drv_q;
    if (accept && io_wr && !io_ctrl_blk && io_reg == `ICTC_DRVHEAD_PORT)
      drv_d[io_chan] = io_wdata[`ICTC_DRVSEL_BIT];
  end
  // ==========================================================
  // Timing class selection
  always_comb begin
    timing_d = timing_q;
    pp_d = pp_q;
    d1_d = d1_q;
    if (accept) begin
      d1_d = drv_q[io_chan];
      if (!data_port) begin
        timing_d = ictc_pkg::ICTC_TIM_COMPAT8;
        pp_d = 1'b0;
      end else if (drv_q[io_chan]) begin
        if (!cur[`ICTC_BIT_D1_FAST_BANK])
          timing_d = ictc_pkg::ICTC_TIM_COMPAT16;
        else if (!io_dma && cur[`ICTC_BIT_D1_DMA_ONLY])
          timing_d = ictc_pkg::ICTC_TIM_COMPAT16;
        else
          timing_d = ictc_pkg::ICTC_TIM_FAST;
        pp_d = cur[`ICTC_BIT_D1_PREFETCH];
      end else begin
        if (!cur[`ICTC_BIT_TIME0])
          timing_d = ictc_pkg::ICTC_TIM_COMPAT16;
        else if (!io_dma && cur[`ICTC_BIT_DTE0])
          timing_d = ictc_pkg::ICTC_TIM_COMPAT16;
        else
          timing_d = ictc_pkg::ICTC_TIM_FAST;
        pp_d = cur[`ICTC_BIT_PPE0];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tim_q[0] <= `ICTC_TIM_RESET;
      tim_q[1] <= `ICTC_TIM_RESET;
      drv_q <= 2'h0;
      timing_q <= ictc_pkg::ICTC_TIM_COMPAT8;
      pp_q <= 1'b0;
      d1_q <= 1'b0;
    end else if (clk_en) begin
      tim_q[0] <= tim_d[0];
      tim_q[1] <= tim_d[1];
      drv_q <= drv_d;
      timing_q <= timing_d;
      pp_q <= pp_d;
      d1_q <= d1_d;
    end
  end
  assign cyc_timing = timing_q;
  assign cyc_prefetch_post = pp_q;
  assign cyc_drive1 = d1_q;
  // ==========================================================
  // Per-channel sequencers
  assign slv_ch[0] = slv_timing_pri;
  assign slv_ch[1] = slv_timing_sec;
  assign iordy_ch = {iordy_sec, iordy_pri};
  assign strobe_pri = strobe_ch[0];
  assign strobe_sec = strobe_ch[1];
  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic use_slv;
    assign start_ch[g] = accept && io_chan == g;
    assign use_slv = tim_q[g][`ICTC_BIT_SEPARATE] && drv_q[g];
    assign smp_ch[g] = use_slv ? slv_ch[g][1:0]
                       : tim_q[g][`ICTC_SMP_HI:`ICTC_SMP_LO];
    assign rtc_ch[g] = use_slv ? slv_ch[g][3:2]
                       : tim_q[g][`ICTC_RTC_HI:`ICTC_RTC_LO];
    assign ren_ch[g] = drv_q[g] ? tim_q[g][`ICTC_BIT_D1_READY_EN]
                       : tim_q[g][`ICTC_BIT_IE0];
    ictc_cycle #(.CW(CW)) u_cyc (
      .clk_sys(clk_sys),
      .srst(srst),
      .clk_en(clk_en),
      .start(start_ch[g]),
      .smp_code(smp_ch[g]),
      .rtc_code(rtc_ch[g]),
      .ready_en(ren_ch[g]),
      .iordy(iordy_ch[g]),
      .strobe(strobe_ch[g]),
      .busy(busy_ch[g]),
      .sample_pulse()
    );
  end
  // ==========================================================
  // Checks
  no_claim_a: assert property (@(posedge clk_sys) disable iff (srst)
    !cur[`ICTC_BIT_DECODE] |-> !io_claim)
    else $error("claim while decode disabled");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    tim_q[0][11:10] == 2'h0 && tim_q[1][11:10] == 2'h0)
    else $error("reserved bits set");
  nondata_compat_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && accept && !data_port) |=>
    cyc_timing == ictc_pkg::ICTC_TIM_COMPAT8)
    else $error("non-data port not 8-bit timing");
  pio_compat_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && accept && data_port && !io_dma && drv_q[io_chan] &&
     cur[`ICTC_BIT_D1_DMA_ONLY]) |=> cyc_timing != ictc_pkg::ICTC_TIM_FAST)
    else $error("drive-1 PIO ran fast");
  post_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && accept && drv_q[io_chan] && !cur[`ICTC_BIT_D1_PREFETCH])
    |=> !cyc_prefetch_post) else $error("posting while disabled");
  shadow_upd_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && accept && io_wr && !io_ctrl_blk && io_reg == 3'h6 &&
     io_chan == 1'b0) |=> drv_q[0] == $past(io_wdata[4]))
    else $error("drive select shadow stale");
  reg_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && cfg_wr && cfg_addr == 8'h42 && cfg_be == 2'h3) |=>
    tim_q[1] == ($past(cfg_wdata) & 16'hF3FF))
    else $error("secondary register not written");
  fast_data_a: assert property (@(posedge clk_sys) disable iff (srst)
    (clk_en && accept && data_port && drv_q[io_chan] &&
     cur[`ICTC_BIT_D1_FAST_BANK] && !cur[`ICTC_BIT_D1_DMA_ONLY]) |=>
    cyc_timing == ictc_pkg::ICTC_TIM_FAST)
    else $error("drive-1 fast timing missing");
endmodule // ictc_channel_timing

// ### ictc_drive_model.sv
// Drive side model: holds ready low for a set number of strobe clocks
`timescale 1ns/10ps
module ictc_drive_model (
  // Clock
  input wire logic clk_sys,
  // Cable
  input wire logic strobe,
  input wire logic [3:0] hold,
  output logic iordy
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!strobe) cnt_q <= 4'h0;
    else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
  end
  // Released line is pulled up, so idle reads ready
  assign iordy = !strobe || (cnt_q >= hold);
endmodule // ictc_drive_model

// ### test_ide_channel_timing_control.sv
// Self-checking bench for the channel timing block
`timescale 1ns/10ps
module test_ide_channel_timing_control;
  // ====
  // Signals
  logic clk_sys = 1'h0, srst = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic io_req = 1'h0, io_wr = 1'h0, io_dma = 1'h0, io_chan = 1'h0;
  logic io_ctrl_blk = 1'h0, dsel = 1'h0, clk_en = 1'h1;
  logic [7:0] cfg_addr = 8'h00, io_wdata = 8'h00;
  logic [1:0] cfg_be = 2'h0, cyc_timing, ct, et;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, v, t;
  logic [15:0] tm [2] = '{16'h0000, 16'h0000};
  logic [3:0] slv_pri = 4'h0, slv_sec = 4'h0, hold = 4'h0, sel;
  logic [2:0] io_reg = 3'h0, rg;
  logic [31:0] w;
  logic io_claim, io_busy, cyc_prefetch_post, cyc_drive1, pp, d1;
  logic iordy_pri, strobe_pri, strobe_sec;
  int error_cnt = 0, checked = 0, cycles = 0, seed = 77797, s, r;

  always #5 clk_sys = ~clk_sys;
  ictc_channel_timing dut_u (.clk_sys, .srst, .clk_en, .cfg_wr,
    .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .slv_timing_pri(slv_pri), .slv_timing_sec(slv_sec), .io_req, .io_wr,
    .io_dma, .io_chan, .io_ctrl_blk, .io_reg, .io_wdata, .io_claim,
    .io_busy, .cyc_timing, .cyc_prefetch_post, .cyc_drive1, .iordy_pri,
    .iordy_sec(1'h1), .strobe_pri, .strobe_sec);
  ictc_drive_model drv_u (.clk_sys, .strobe(strobe_pri), .hold,
    .iordy(iordy_pri));

  // ====
  // Tasks
  task automatic stop_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rng(string n, int lo, int hi, int g);
    checked++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask
  task automatic cfg_write(logic [7:0] a, logic [1:0] be, logic [15:0] d);
    @(posedge clk_sys);
    #1 {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'h1, a, be, d};
    @(posedge clk_sys);
    #1 cfg_wr = 1'h0;
    if (a == 8'h40 || a == 8'h42) begin
      if (be[0]) tm[a[1]][7:0] = d[7:0];
      if (be[1]) tm[a[1]][15:8] = d[15:8] & 8'hF3;
    end
  endtask
  task automatic cfg_read(logic [7:0] a, logic [15:0] e);
    @(posedge clk_sys);
    #1 {cfg_rd, cfg_addr} = {1'h1, a};
    #2 chk("cfg_rdata", e, cfg_rdata);
    cfg_rd = 1'h0;
  endtask
  function automatic logic [1:0] exp_tim(logic [15:0] t, logic dma,
      logic ctl, logic [2:0] rg, logic d);
    logic fast, dte;
    fast = d ? t[4] : t[0];
    dte = d ? t[7] : t[3];
    if (ctl || rg != 3'h0) return ictc_pkg::ICTC_TIM_COMPAT8;
    if (!fast || (dte && !dma)) return ictc_pkg::ICTC_TIM_COMPAT16;
    return ictc_pkg::ICTC_TIM_FAST;
  endfunction
  task automatic io_go(logic ch, logic dma, logic ctl, logic [2:0] rg,
      logic wr, logic [7:0] wd, logic ck);
    @(posedge clk_sys);
    #1 {io_chan, io_dma, io_ctrl_blk, io_reg, io_wr, io_wdata} =
      {ch, dma, ctl, rg, wr, wd};
    io_req = 1'h1;
    t = tm[ch];
    #1 chk("io_claim", {15'h0, t[15]}, {15'h0, io_claim});
    @(posedge clk_sys);
    #1 io_req = 1'h0;
    {ct, pp, d1} = {cyc_timing, cyc_prefetch_post, cyc_drive1};
    s = 0;
    r = 0;
    while ((strobe_pri || strobe_sec) && s < 40) begin
      s++;
      @(posedge clk_sys);
      #1;
    end
    while (io_busy && r < 40) begin
      r++;
      @(posedge clk_sys);
      #1;
    end
    if (ck && t[15]) begin
      et = exp_tim(t, dma, ctl, rg, dsel);
      chk("cyc_timing", {14'h0, et}, {14'h0, ct});
      chk("cyc_drive1", {15'h0, dsel}, {15'h0, d1});
      if (!ctl && rg == 3'h0)
        chk("prefetch", {15'h0, (dsel ? t[6] : t[2])}, {15'h0, pp});
      sel = (dsel && t[14]) ? slv_pri : {t[9:8], t[13:12]};
      if ((dsel ? t[5] : t[1]) && hold > 4'h5)
        rng("strobe", hold, hold + 2, s);
      else
        rng("strobe", 5 - sel[1:0], 6 - sel[1:0], s);
      rng("recovery", 4 - sel[3:2], 6 - sel[3:2], r);
    end
    if (t[15] && !ch && wr && !ctl && rg == 3'h6) dsel = wd[4];
  endtask

  // ====
  // Sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 srst = 1'h0;
    cfg_read(8'h40, 16'h0000);
    cfg_read(8'h42, 16'h0000);
    cfg_write(8'h42, 2'h3, 16'hFFFF);
    cfg_read(8'h42, 16'hF3FF);
    cfg_read(8'h40, 16'h0000);
    cfg_read(8'h50, 16'h0000);
    v = tm[0];
    clk_en = 1'h0;
    cfg_write(8'h40, 2'h3, 16'h8123);
    tm[0] = v;
    clk_en = 1'h1;
    cfg_read(8'h40, v);
    $display("test registers done");
    io_go(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 8'h00, 1'h1);
    io_go(1'h1, 1'h0, 1'h0, 3'h0, 1'h0, 8'h00, 1'h0);
    for (int c = 0; c < 4; c++) begin
      cfg_write(8'h40, 2'h3, {2'h2, 2'(c), 2'h0, 2'(c), 8'h00});
      io_go(1'h0, 1'h0, 1'h0, 3'h0, 1'h0, 8'h00, 1'h1);
    end
    $display("test timing codes done");
    for (int i = 0; i < 60; i++) begin
      v = 16'($random(seed));
      w = $random(seed);
      slv_pri = w[11:8];
      hold = w[12] ? 4'h9 : 4'h0;
      rg = w[3] ? 3'h0 : w[6:4];
      cfg_write(8'h40, 2'h3, v | 16'h8000);
      io_go(1'h0, 1'h0, 1'h0, 3'h6, 1'h1, {3'h0, v[15], 4'h0}, 1'h0);
      io_go(1'h0, w[0], w[1] & w[2], rg, 1'h0, 8'h00, 1'h1);
    end
    $display("test random done");
    stop_test();
  end
endmodule // test_ide_channel_timing_control
